// file: ctc_params.svh
// constants for the compact timer control block
// assumes inclusion by the single design file and its bench
`ifndef CTC_PARAMS_SVH
`define CTC_PARAMS_SVH
// register indices on the plain register port
`define CTC_ADDR_CTRL0 3'h0
`define CTC_ADDR_CTRL1 3'h1
`define CTC_ADDR_CNT_LO 3'h2
`define CTC_ADDR_CNT_HI 3'h3
`define CTC_ADDR_CMPA_LO 3'h4
`define CTC_ADDR_CMPA_HI 3'h5
`define CTC_ADDR_PERIOD 3'h6
`define CTC_ADDR_FLAGS 3'h7
// reset values
`define CTC_CTRL_RST 8'h00
`define CTC_BYTE_RST 8'h00
`define CTC_CNT_RST 16'h0000
// clock select codes
`define CTC_CK_SYS4 3'h0
`define CTC_CK_SYS 3'h1
`define CTC_CK_HI16 3'h2
`define CTC_CK_HI64 3'h3
`define CTC_CK_SUB0 3'h4
`define CTC_CK_SUB1 3'h5
`define CTC_CK_EXT_RISE 3'h6
`define CTC_CK_EXT_FALL 3'h7
// prescaler terminal values
`define CTC_DIV4_LAST 6'h03
`define CTC_DIV16_LAST 6'h0f
`define CTC_DIV64_LAST 6'h3f
// output function codes
`define CTC_IO_NONE 2'h0
`define CTC_IO_LOW 2'h1
`define CTC_IO_HIGH 2'h2
`define CTC_IO_TOGGLE 2'h3
`define CTC_IO_PWM 2'h2
`endif

// file: ctc_pkg.sv
// types for the compact timer control block
// assumes the params header is on the include path
package ctc_pkg;
    // operating mode encodings
    typedef enum logic [1:0]
    {
        CTC_MODE_CMP = 2'h0,
        CTC_MODE_UNDEF = 2'h1,
        CTC_MODE_PWM = 2'h2,
        CTC_MODE_TMR = 2'h3
    } ctc_mode_t;
    // first control register layout
    typedef struct packed
    {
        logic counter_pause;
        logic [2:0] clock_select;
        logic counter_on;
        logic [2:0] unused;
    } ctc_ctrl0_t;
    // second control register layout
    typedef struct packed
    {
        ctc_mode_t mode_select;
        logic [1:0] output_function;
        logic output_initial_level;
        logic output_invert;
        logic duty_period_swap;
        logic clear_select;
    } ctc_ctrl1_t;
    // register port request bundle
    typedef struct packed
    {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ctc_req_t;
endpackage

// file: ctc_timer.sv
// compact 16-bit count-up timer with compare and pwm output
// assumes one 125 MHz clock; high and sub clocks arrive as ticks on that clock
//
// Functional notes
// - pause holds counter, resume from held value
// - pause rising edge keeps present count
// - clock_select picks counter clock source
// - counter runs only while counter_on set
// - counter_on rise clears counter; fall holds
// - counter_on rise restores initial output level outside timer mode
// - control0 bits two to zero read zero
// - mode_select picks compare, pwm, timer mode
// - compare mode match A: none, low, high, toggle
// - pwm mode: inactive, active, or waveform
// - match to same level shows no change
// - initial level sets start level or pwm polarity
// - output_invert inverts the output pin
// - duty_period_swap exchanges duty and period roles
// - clear_select picks A match or P match clear
// - zero period value means clear on overflow
// - pwm mode ignores clear_select
// - counter read-only pair, compare A pair, 8-bit period
// - timer mode output level undefined
// - P compares high byte, A full count
// - low bytes via buffer, high access transfers
// - compare mode with A clear never sets P flag
`timescale 1ns/10ps
`include "ctc_params.svh"

module ctc_timer
    import ctc_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic high_tick_i,
    input wire logic sub_tick_i,
    input wire logic ext_clock_pin_i,
    output logic timer_output_pin_o,
    output logic timer_output_en_o,
    output logic match_a_flag_o,
    output logic match_p_flag_o
);

    // =====================================================
    // register port and control storage
    // =====================================================
    ctc_req_t req; // bundled request
    ctc_ctrl0_t ctrl0_reg; // first control register
    ctc_ctrl1_t ctrl1_reg; // second control register
    logic [CNT_W-1:0] count_reg; // main counter
    logic [CNT_W-1:0] cmpa_reg; // compare A value
    logic [7:0] period_reg; // compare P value
    logic [7:0] wbuf_reg; // low byte write buffer
    logic [7:0] rbuf_reg; // low byte read buffer
    logic flag_a_reg; // sticky match A
    logic flag_p_reg; // sticky match P
    logic out_reg; // output level before inversion
    logic on_d_reg; // counter_on delayed for edge
    logic [7:0] rdata_reg; // read data stage

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    // write access decode, used at several places
    function automatic logic wr_at(input ctc_req_t r, input logic [2:0] a);
        wr_at = r.wr && (r.addr == a);
    endfunction

    // control registers; reserved bits never stored
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl0_reg <= `CTC_CTRL_RST;
            ctrl1_reg <= `CTC_CTRL_RST;
        end
        else
        begin
            if (wr_at(req, `CTC_ADDR_CTRL0))
                ctrl0_reg <= {req.wdata[7:3], 3'h0};
            if (wr_at(req, `CTC_ADDR_CTRL1))
                ctrl1_reg <= req.wdata;
        end
    end

    // compare A pair: low byte waits in buffer until high byte write
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wbuf_reg <= `CTC_BYTE_RST;
            cmpa_reg <= `CTC_CNT_RST;
            period_reg <= `CTC_BYTE_RST;
        end
        else
        begin
            if (wr_at(req, `CTC_ADDR_CMPA_LO))
                wbuf_reg <= req.wdata;
            if (wr_at(req, `CTC_ADDR_CMPA_HI))
                cmpa_reg <= {req.wdata, wbuf_reg};
            if (wr_at(req, `CTC_ADDR_PERIOD))
                period_reg <= req.wdata;
        end
    end

    // read path; high byte reads capture low byte into buffer
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rdata_reg <= `CTC_BYTE_RST;
            rbuf_reg <= `CTC_BYTE_RST;
        end
        else if (req.rd)
        begin
            unique case (req.addr)
                `CTC_ADDR_CTRL0: rdata_reg <= {ctrl0_reg[7:3], 3'h0};
                `CTC_ADDR_CTRL1: rdata_reg <= ctrl1_reg;
                `CTC_ADDR_CNT_LO: rdata_reg <= rbuf_reg;
                `CTC_ADDR_CNT_HI:
                begin
                    rdata_reg <= count_reg[15:8];
                    rbuf_reg <= count_reg[7:0];
                end
                `CTC_ADDR_CMPA_LO: rdata_reg <= rbuf_reg;
                `CTC_ADDR_CMPA_HI:
                begin
                    rdata_reg <= cmpa_reg[15:8];
                    rbuf_reg <= cmpa_reg[7:0];
                end
                `CTC_ADDR_PERIOD: rdata_reg <= period_reg;
                `CTC_ADDR_FLAGS: rdata_reg <= {6'h00, flag_p_reg, flag_a_reg};
            endcase
        end
        else
            rdata_reg <= `CTC_BYTE_RST;
    end
    assign reg_rdata_o = rdata_reg;

    // =====================================================
    // clock source selection
    // =====================================================
    logic [2:0] ext_sync_reg; // three stage pin synchroniser
    logic [5:0] pre_reg; // free prescaler
    logic ext_lvl_reg; // agreed pin level
    logic ext_rise; // one cycle rising edge
    logic ext_fall; // one cycle falling edge
    logic tick; // selected count enable
    logic hi_d_reg; // high tick registered, one cycle late
    logic [5:0] hi_cnt_reg; // high clock divider

    // synchroniser; stage one only feeds stage two
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ext_sync_reg <= 3'h0;
            ext_lvl_reg <= 1'b0;
        end
        else
        begin
            ext_sync_reg <= {ext_sync_reg[1:0], ext_clock_pin_i};
            if (ext_sync_reg[1] == ext_sync_reg[2])
                ext_lvl_reg <= ext_sync_reg[2];
        end
    end
    assign ext_rise = (ext_sync_reg[1] == ext_sync_reg[2]) && ext_sync_reg[2] && !ext_lvl_reg;
    assign ext_fall = (ext_sync_reg[1] == ext_sync_reg[2]) && !ext_sync_reg[2] && ext_lvl_reg;

    // system and high clock prescalers
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pre_reg <= 6'h00;
            hi_cnt_reg <= 6'h00;
            hi_d_reg <= 1'b0;
        end
        else
        begin
            pre_reg <= (pre_reg == `CTC_DIV4_LAST) ? 6'h00 : pre_reg + 6'h01;
            hi_d_reg <= 1'b0;
            if (high_tick_i)
            begin
                hi_cnt_reg <= hi_cnt_reg + 6'h01;
                hi_d_reg <= 1'b1;
            end
        end
    end

    // count enable multiplexer
    always_comb
    begin
        unique case (ctrl0_reg.clock_select)
            `CTC_CK_SYS4: tick = (pre_reg == `CTC_DIV4_LAST);
            `CTC_CK_SYS: tick = 1'b1;
            `CTC_CK_HI16: tick = hi_d_reg && (hi_cnt_reg[3:0] == `CTC_DIV16_LAST);
            `CTC_CK_HI64: tick = hi_d_reg && (hi_cnt_reg == `CTC_DIV64_LAST);
            `CTC_CK_SUB0, `CTC_CK_SUB1: tick = sub_tick_i;
            `CTC_CK_EXT_RISE: tick = ext_rise;
            `CTC_CK_EXT_FALL: tick = ext_fall;
        endcase
    end

    // =====================================================
    // counter, comparators and clear
    // =====================================================
    logic run; // counter may advance
    logic on_rise; // counter_on low to high
    logic match_a; // comparator A hit
    logic match_p; // comparator P hit
    logic ovf; // counter at top
    logic clr; // counter clear this tick
    logic is_pwm; // pwm mode active
    logic [7:0] per_byte; // p compare byte in use
    logic use_a_clear; // clear from comparator A

    assign on_rise = ctrl0_reg.counter_on && !on_d_reg;
    assign run = ctrl0_reg.counter_on && !ctrl0_reg.counter_pause && tick;
    assign is_pwm = (ctrl1_reg.mode_select == CTC_MODE_PWM);
    assign per_byte = period_reg;
    assign match_a = run && (count_reg == cmpa_reg);
    // P hit on the last count before P*256, so a zero period lands on ffff
    assign match_p = run && (count_reg[15:8] == (per_byte - 8'h01)) && (count_reg[7:0] == 8'hff);
    assign ovf = run && (count_reg == 16'hffff);
    // pwm: period register from swap bit; else clear_select
    assign use_a_clear = is_pwm ? ctrl1_reg.duty_period_swap : ctrl1_reg.clear_select;
    always_comb
    begin
        if (use_a_clear)
            clr = match_a || ovf;
        else if (per_byte == 8'h00)
            clr = ovf;
        else
            clr = match_p;
    end

    // counter; held while paused or off
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            count_reg <= `CTC_CNT_RST;
            on_d_reg <= 1'b0;
        end
        else
        begin
            on_d_reg <= ctrl0_reg.counter_on;
            if (on_rise)
                count_reg <= `CTC_CNT_RST;
            else if (clr)
                count_reg <= `CTC_CNT_RST;
            else if (run)
                count_reg <= count_reg + 16'h0001;
        end
    end

    // sticky flags; set beats software clear at flag register
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            flag_a_reg <= 1'b0;
            flag_p_reg <= 1'b0;
        end
        else
        begin
            if (match_a)
                flag_a_reg <= 1'b1;
            else if (wr_at(req, `CTC_ADDR_FLAGS) && req.wdata[0])
                flag_a_reg <= 1'b0;
            if (match_p && !(ctrl1_reg.clear_select && !is_pwm))
                flag_p_reg <= 1'b1;
            else if (wr_at(req, `CTC_ADDR_FLAGS) && req.wdata[1])
                flag_p_reg <= 1'b0;
        end
    end
    assign match_a_flag_o = flag_a_reg;
    assign match_p_flag_o = flag_p_reg;

    // =====================================================
    // output pin
    // =====================================================
    logic pwm_period_wrap; // pwm period end
    logic pwm_duty_hit; // pwm duty end

    assign pwm_duty_hit = ctrl1_reg.duty_period_swap ? match_p : match_a;
    assign pwm_period_wrap = clr;

    // output level; active level given by output_initial_level
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            out_reg <= 1'b0;
        end
        else if (on_rise && (ctrl1_reg.mode_select != CTC_MODE_TMR))
            out_reg <= ctrl1_reg.output_initial_level;
        else if (is_pwm)
            unique case (ctrl1_reg.output_function)
                `CTC_IO_NONE: out_reg <= !ctrl1_reg.output_initial_level;
                `CTC_IO_LOW: out_reg <= ctrl1_reg.output_initial_level;
                `CTC_IO_PWM:
                begin
                    if (pwm_duty_hit)
                        out_reg <= !ctrl1_reg.output_initial_level;
                    else if (pwm_period_wrap)
                        out_reg <= ctrl1_reg.output_initial_level;
                end
                default: out_reg <= out_reg;
            endcase
        else if (match_a && (ctrl1_reg.mode_select == CTC_MODE_CMP))
            unique case (ctrl1_reg.output_function)
                `CTC_IO_NONE: out_reg <= out_reg;
                `CTC_IO_LOW: out_reg <= 1'b0;
                `CTC_IO_HIGH: out_reg <= 1'b1;
                `CTC_IO_TOGGLE: out_reg <= !out_reg;
            endcase
    end
    assign timer_output_pin_o = out_reg ^ ctrl1_reg.output_invert;
    // pin released in timer mode, level there is don't care
    assign timer_output_en_o = (ctrl1_reg.mode_select != CTC_MODE_TMR);

    // =====================================================
    // checks
    // =====================================================
    pause_holds_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ctrl0_reg.counter_pause && !on_rise |=> $stable(count_reg))
        else $error("counter moved while paused");
    pause_entry_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(ctrl0_reg.counter_pause) && on_d_reg |=> $stable(count_reg))
        else $error("count changed on pause");
    off_holds_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !ctrl0_reg.counter_on ##1 !ctrl0_reg.counter_on |-> $stable(count_reg))
        else $error("counter moved while off");
    on_clears_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        on_rise |=> count_reg == 16'h0000)
        else $error("counter not cleared on enable");
    init_level_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        on_rise && ctrl1_reg.mode_select == CTC_MODE_CMP |=> out_reg == $past(ctrl1_reg.output_initial_level))
        else $error("output not reset to initial level");
    rsvd_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        req.rd && req.addr == `CTC_ADDR_CTRL0 |=> reg_rdata_o[2:0] == 3'h0)
        else $error("reserved bits not zero");
    pflag_block_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !flag_p_reg && ctrl1_reg.clear_select && ctrl1_reg.mode_select == CTC_MODE_CMP
        && !(wr_at(req, `CTC_ADDR_CTRL1)) |=> !flag_p_reg)
        else $error("p flag set with A clear");
    aflag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        match_a |=> flag_a_reg [*2] or (flag_a_reg ##1 match_a))
        else $error("match flag not held");
    invert_pin_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $changed(ctrl1_reg.output_invert) && $stable(out_reg) |-> $changed(timer_output_pin_o))
        else $error("pin polarity wrong");

endmodule // ctc_timer

// file: ctc_timer_tb.sv
// self-checking bench for the compact timer control block
// assumes ctc_pkg compiled first and ctc_params.svh on the include path
`timescale 1ns/10ps
`include "ctc_params.svh"

module ctc_timer_tb
    import ctc_pkg::*;
;
    // ==========================================
    // design ports and bench state
    logic ref_clk_i;
    logic rst_b_i;
    logic [2:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [7:0] reg_rdata_o;
    logic high_tick_i;
    logic sub_tick_i;
    logic ext_clock_pin_i;
    logic timer_output_pin_o;
    logic timer_output_en_o;
    logic match_a_flag_o;
    logic match_p_flag_o;
    int err_total;
    int checked;
    int cyc_cnt;
    logic [7:0] rv;
    logic [15:0] cv;
    logic [1:0] io;
    logic ex;
    // source table: select code, stimulus kind, pulse count, expected count
    logic [2:0] sels [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    int kinds [6] = '{0, 0, 1, 1, 2, 2};
    int nums [6] = '{32, 128, 5, 3, 5, 4};
    logic [15:0] exps [6] = '{16'h0002, 16'h0002, 16'h0005, 16'h0003, 16'h0005, 16'h0004};

    // ==========================================
    // device under test
    ctc_timer uut
    (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .high_tick_i(high_tick_i),
        .sub_tick_i(sub_tick_i),
        .ext_clock_pin_i(ext_clock_pin_i),
        .timer_output_pin_o(timer_output_pin_o),
        .timer_output_en_o(timer_output_en_o),
        .match_a_flag_o(match_a_flag_o),
        .match_p_flag_o(match_p_flag_o)
    );

    // ==========================================
    // clock, 8 ns period
    initial
    begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // hang guard, well above the expected run length
    always @(posedge ref_clk_i)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000)
        begin
            err_total++;
            complete_run();
        end
    end

    // ==========================================
    // bus and check tasks
    // one-cycle write strobe, released at the sampling edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    // high byte first so the low byte comes from the snapshot
    task automatic rdcnt(output logic [15:0] v);
        logic [7:0] h;
        logic [7:0] l;
        rd(`CTC_ADDR_CNT_HI, h);
        rd(`CTC_ADDR_CNT_LO, l);
        v = {h, l};
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic pinchk(input logic e);
        #1;
        chk({15'h0000, timer_output_pin_o}, {15'h0000, e});
    endtask

    // kind 0 high tick, 1 sub tick, 2 external pin edges
    task automatic pulse(input int kind, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk_i);
            if (kind == 0)
                high_tick_i <= 1'b1;
            else if (kind == 1)
                sub_tick_i <= 1'b1;
            @(posedge ref_clk_i);
            high_tick_i <= 1'b0;
            sub_tick_i <= 1'b0;
            if (kind == 2)
            begin
                ext_clock_pin_i <= 1'b1;
                cyc(4);
                ext_clock_pin_i <= 1'b0;
                cyc(4);
            end
        end
        cyc(8);
    endtask

    function automatic logic [7:0] c1(ctc_mode_t m, logic [1:0] f, logic l, logic v, logic s, logic c);
        return {m, f, l, v, s, c};
    endfunction

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        rst_b_i = 1'b0;
        reg_addr_i = 3'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        high_tick_i = 1'b0;
        sub_tick_i = 1'b0;
        ext_clock_pin_i = 1'b0;
        err_total = 0;
        checked = 0;
        cyc_cnt = 0;
        repeat (4) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        // reset values of every register
        for (int a = 0; a < 8; a++)
            rdchk(a[2:0], 8'h00);
        wr(`CTC_ADDR_CTRL0, 8'hff);
        rdchk(`CTC_ADDR_CTRL0, 8'hf8);
        wr(`CTC_ADDR_CTRL0, 8'h00);
        wr(`CTC_ADDR_CTRL1, 8'ha5);
        rdchk(`CTC_ADDR_CTRL1, 8'ha5);
        // counter pair ignores writes
        wr(`CTC_ADDR_CNT_HI, 8'h55);
        wr(`CTC_ADDR_CNT_LO, 8'h55);
        rdcnt(cv);
        chk(cv, 16'h0000);
        // compare pair low byte only moves on a high write
        wr(`CTC_ADDR_CMPA_LO, 8'h34);
        wr(`CTC_ADDR_CMPA_HI, 8'h12);
        wr(`CTC_ADDR_CMPA_LO, 8'h56);
        rdchk(`CTC_ADDR_CMPA_HI, 8'h12);
        rdchk(`CTC_ADDR_CMPA_LO, 8'h34);
        // timer mode: pause, clear on rise, hold on fall
        wr(`CTC_ADDR_CTRL1, c1(CTC_MODE_TMR, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        wr(`CTC_ADDR_CTRL0, 8'h00);
        #1;
        chk({15'h0000, timer_output_en_o}, 16'h0000);
        wr(`CTC_ADDR_CTRL0, 8'h98);
        rdcnt(cv);
        chk(cv, 16'h0000);
        wr(`CTC_ADDR_CTRL0, 8'h18);
        cyc(20);
        wr(`CTC_ADDR_CTRL0, 8'h98);
        rdcnt(cv);
        chk(cv, 16'h0016);
        cyc(10);
        rdcnt(cv);
        chk(cv, 16'h0016);
        wr(`CTC_ADDR_CTRL0, 8'h10);
        rdcnt(cv);
        chk(cv, 16'h0016);
        // every clock source from the table
        for (int k = 0; k < 6; k++)
        begin
            wr(`CTC_ADDR_CTRL0, 8'h00);
            wr(`CTC_ADDR_CTRL0, {1'b0, sels[k], 1'b1, 3'h0});
            pulse(kinds[k], nums[k]);
            wr(`CTC_ADDR_CTRL0, {1'b0, sels[k], 1'b0, 3'h0});
            rdcnt(cv);
            chk(cv, exps[k]);
        end
        // compare mode: every action, level and polarity, one match each
        wr(`CTC_ADDR_CMPA_LO, 8'h10);
        wr(`CTC_ADDR_CMPA_HI, 8'h00);
        for (int k = 0; k < 16; k++)
        begin
            io = k[3:2];
            ex = (io == 2'h0) ? k[1] : (io == 2'h1) ? 1'b0 : (io == 2'h2) ? 1'b1 : ~k[1];
            wr(`CTC_ADDR_CTRL0, 8'h00);
            wr(`CTC_ADDR_CTRL1, c1(CTC_MODE_CMP, io, k[1], k[0], 1'b0, 1'b0));
            wr(`CTC_ADDR_CTRL0, 8'h18);
            cyc(2);
            pinchk(k[1] ^ k[0]);
            cyc(40);
            pinchk(ex ^ k[0]);
        end
        chk({15'h0000, timer_output_en_o}, 16'h0001);
        rdchk(`CTC_ADDR_FLAGS, 8'h01);
        wr(`CTC_ADDR_FLAGS, 8'h03);
        rdchk(`CTC_ADDR_FLAGS, 8'h00);
        // period compare clears at the end of its 256 block
        wr(`CTC_ADDR_CTRL0, 8'h00);
        wr(`CTC_ADDR_CMPA_LO, 8'hff);
        wr(`CTC_ADDR_CMPA_HI, 8'hff);
        wr(`CTC_ADDR_PERIOD, 8'h01);
        wr(`CTC_ADDR_CTRL1, c1(CTC_MODE_CMP, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        wr(`CTC_ADDR_CTRL0, 8'h18);
        cyc(600);
        chk({15'h0000, match_p_flag_o}, 16'h0001);
        wr(`CTC_ADDR_CTRL0, 8'h98);
        rdcnt(cv);
        chk({15'h0000, cv < 16'h0100}, 16'h0001);
        // compare A clear: no period flag
        wr(`CTC_ADDR_CTRL0, 8'h00);
        wr(`CTC_ADDR_CMPA_LO, 8'h00);
        wr(`CTC_ADDR_CMPA_HI, 8'h01);
        wr(`CTC_ADDR_CTRL1, c1(CTC_MODE_CMP, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1));
        wr(`CTC_ADDR_FLAGS, 8'h03);
        wr(`CTC_ADDR_CTRL0, 8'h18);
        cyc(600);
        chk({14'h0000, match_p_flag_o, match_a_flag_o}, 16'h0001);
        wr(`CTC_ADDR_CTRL0, 8'h98);
        rdcnt(cv);
        chk({15'h0000, cv <= 16'h0100}, 16'h0001);
        // pwm, period from P, clear select ignored
        wr(`CTC_ADDR_CTRL0, 8'h00);
        wr(`CTC_ADDR_CMPA_LO, 8'h80);
        wr(`CTC_ADDR_CMPA_HI, 8'h00);
        wr(`CTC_ADDR_CTRL1, c1(CTC_MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1));
        wr(`CTC_ADDR_CTRL0, 8'h18);
        cyc(20);
        pinchk(1'b1);
        cyc(200);
        pinchk(1'b0);
        cyc(310);
        pinchk(1'b1);
        // pwm swapped roles, inverted pin
        wr(`CTC_ADDR_CTRL0, 8'h00);
        wr(`CTC_ADDR_CMPA_HI, 8'h03);
        wr(`CTC_ADDR_CTRL1, c1(CTC_MODE_PWM, 2'h2, 1'b1, 1'b1, 1'b1, 1'b0));
        wr(`CTC_ADDR_CTRL0, 8'h18);
        cyc(100);
        pinchk(1'b0);
        cyc(500);
        pinchk(1'b1);
        // pwm forced inactive and active levels
        for (int j = 0; j < 2; j++)
        begin
            wr(`CTC_ADDR_CTRL0, 8'h00);
            wr(`CTC_ADDR_CTRL1, c1(CTC_MODE_PWM, j[1:0], 1'b1, 1'b0, 1'b0, 1'b0));
            wr(`CTC_ADDR_CTRL0, 8'h18);
            cyc(30);
            pinchk(j[0]);
        end
        complete_run();
    end
endmodule // ctc_timer_tb
